/* verilog/dcg_cfg.svh */
// constants of the delay-locked clock output generator: offsets, reset values, counts
// assumes inclusion by bare name from the tap, lock detector and top design files of the block
//
// Summary of operation
// - locked doubled output runs 2x at 50/50
// - unlocked doubled output is 1x at 25/75
// - high-frequency variant drives no doubled output
// - divided output divides by configured factor
// - divided 50/50, except fast-mode 1/3 and 2/5
// - zero-degree output is deskewed source copy
// - 90/180/270 copies; high-frequency mode only 180
// - copies lag by 25, 50, 75 percent
// - duty correction on gives 50/50 1x outputs
// - correction off follows source duty cycle
// - lock indicator only after lock achieved
// - hold configuration completion until lock if enabled
// - loop reset returns delay taps to zero
`ifndef DCG_CFG_SVH
`define DCG_CFG_SVH

// ****************************************************************
// measurement and alignment
// ****************************************************************
`define DCG_PERIOD_W 12
`define DCG_COMP_LAT 4
`define DCG_LOCK_PERIODS 3000
`define DCG_LOCK_TOL 1
`define DCG_MATCH_W 12

// ****************************************************************
// divide factors in half-source-period units
// ****************************************************************
`define DCG_HU_W 6
`define DCG_HU_1P5 6'h03
`define DCG_HU_2 6'h04
`define DCG_HU_2P5 6'h05
`define DCG_HU_3 6'h06
`define DCG_HU_4 6'h08
`define DCG_HU_5 6'h0a
`define DCG_HU_8 6'h10
`define DCG_HU_16 6'h20

// ****************************************************************
// reset values
// ****************************************************************
`define DCG_OUT_RST 1'b0
`define DCG_LOCK_RST 1'b0

`endif

/* verilog/dcg_pkg.sv */
// types of the delay-locked clock output generator
// assumes nothing beyond a systemverilog compiler
package dcg_pkg;

  // divided output factor selection
  typedef enum logic [2:0] {
    DCG_DIV_1P5,
    DCG_DIV_2,
    DCG_DIV_2P5,
    DCG_DIV_3,
    DCG_DIV_4,
    DCG_DIV_5,
    DCG_DIV_8,
    DCG_DIV_16
  } dcg_div_type;

  // static configuration, set before the loop is released
  typedef struct packed {
    logic high_freq_mode;          // high-frequency variant
    logic dcc_enable;              // duty-cycle correction
    logic hold_config_until_lock;  // delay configuration completion
    dcg_div_type divide_factor_cfg; // divided output factor
  } dcg_cfg_type;

  // generated clock bundle
  typedef struct packed {
    logic phase0_out;
    logic phase90_out;
    logic phase180_out;
    logic phase270_out;
    logic double_freq_out;
    logic divided_clk_out;
  } dcg_clk_out_type;

endpackage

/* verilog/dcg_phase_tap.sv */
// one phase tap: a registered clock that is high for width cycles after
// a shift point within the measured source period
// assumes pos already wraps at period and shift is below period
`timescale 1ns/1ps
`default_nettype none
`include "dcg_cfg.svh"
module dcg_phase_tap #(
  parameter int PW = `DCG_PERIOD_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // timing inputs
  input wire logic [PW-1:0] pos,
  input wire logic [PW-1:0] period,
  input wire logic [PW-1:0] shift,
  input wire logic [PW-1:0] width,
  input wire logic enable,
  // tap output
  output logic tap_out
);
  logic tap_q;
  logic tap_d;
  logic [PW-1:0] rel; // position relative to this tap's rising point

  // fold the shift back into the period so the tap lags phase zero
  always_comb begin
    rel = (pos >= shift) ? (pos - shift) : (pos + period - shift);
    tap_d = enable & (rel < width);
  end

  // registered so the clock leaves the block without combinational hazards
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tap_q <= `DCG_OUT_RST;
    end else begin
      tap_q <= tap_d;
    end
  end

  assign tap_out = tap_q;
endmodule
`default_nettype wire

/* verilog/dcg_lock_det.sv */
// lock detector: counts consecutive source periods whose length agrees
// with the previous one and declares lock after enough of them
// assumes sample is a one-cycle pulse per source period on mclk
`timescale 1ns/1ps
`default_nettype none
`include "dcg_cfg.svh"
module dcg_lock_det #(
  parameter int PW = `DCG_PERIOD_W,
  parameter int LOCK_PERIODS = `DCG_LOCK_PERIODS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // measurement
  input wire logic clear,
  input wire logic sample,
  input wire logic [PW-1:0] period,
  // status
  output logic locked
);
  logic [PW-1:0] prev_q, prev_d;            // last accepted period
  logic [`DCG_MATCH_W-1:0] match_q, match_d; // agreeing periods so far
  logic locked_q, locked_d;
  logic [PW-1:0] diff;
  logic agree;

  // next state: a mismatch restarts counting and drops lock
  always_comb begin
    diff = (period > prev_q) ? (period - prev_q) : (prev_q - period);
    agree = (period != '0) && (diff <= PW'(`DCG_LOCK_TOL));
    prev_d = prev_q;
    match_d = match_q;
    locked_d = locked_q;
    if (clear) begin
      prev_d = '0;
      match_d = '0;
      locked_d = `DCG_LOCK_RST;
    end else if (sample) begin
      prev_d = period;
      if (!agree) begin
        match_d = '0;
        locked_d = 1'b0;
      end else if (match_q >= `DCG_MATCH_W'(LOCK_PERIODS - 1)) begin
        locked_d = 1'b1;
      end else begin
        match_d = match_q + 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= '0;
      match_q <= '0;
      locked_q <= `DCG_LOCK_RST;
    end else begin
      prev_q <= prev_d;
      match_q <= match_d;
      locked_q <= locked_d;
    end
  end

  assign locked = locked_q;
endmodule
`default_nettype wire

/* verilog/dcg_top.sv */
// delay-locked clock output generator: measures the source clock on mclk,
// predicts its edges and rebuilds deskewed, shifted, doubled and divided copies
// assumes source_clk_in is slower than mclk/8 and comes from outside the mclk domain
// assumes cfg and config_done_in are driven by logic on mclk
`timescale 1ns/1ps
`default_nettype none
`include "dcg_cfg.svh"
module dcg_top #(
  parameter int PW = `DCG_PERIOD_W,
  parameter int LOCK_PERIODS = `DCG_LOCK_PERIODS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // pins from outside the clock domain
  input wire logic source_clk_in,
  input wire logic loop_rst_in,
  // configuration from on-chip logic
  input wire dcg_pkg::dcg_cfg_type cfg,
  input wire logic config_done_in,
  // generated clocks and status
  output dcg_pkg::dcg_clk_out_type clk_out,
  output logic locked_out,
  output logic config_release_out
);
  import dcg_pkg::*;

  localparam int DW = PW + `DCG_HU_W; // divided period counter width

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic src_meta_q, src_sync_q, src_prev_q; // source clock, two stages and history
  logic rst_meta_q, rst_sync_q;             // loop reset pin, two stages
  logic rise, fall;

  // plain two-flop chains; only the second stage and the source history feed logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_meta_q <= 1'b0;
      src_sync_q <= 1'b0;
      src_prev_q <= 1'b0;
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end else begin
      src_meta_q <= source_clk_in;
      src_sync_q <= src_meta_q;
      src_prev_q <= src_sync_q;
      rst_meta_q <= loop_rst_in;
      rst_sync_q <= rst_meta_q;
    end
  end

  // edge strobes of the synchronised source
  always_comb begin
    rise = src_sync_q & ~src_prev_q;
    fall = ~src_sync_q & src_prev_q;
  end

  // ****************************************************************
  // period and high-time measurement
  // ****************************************************************
  logic [PW-1:0] cnt_q, cnt_d;       // cycles since last rising edge
  logic [PW-1:0] period_q, period_d; // last full source period
  logic [PW-1:0] high_q, high_d;     // last source high time
  logic sat;

  // a saturated counter means the source stopped; report period zero so
  // the lock detector sees a mismatch rather than a bogus value
  always_comb begin
    sat = &cnt_q;
    cnt_d = cnt_q;
    period_d = period_q;
    high_d = high_q;
    if (rst_sync_q) begin
      cnt_d = '0;
      period_d = '0;
      high_d = '0;
    end else begin
      if (rise) begin
        cnt_d = '0;
        period_d = sat ? '0 : (cnt_q + 1'b1);
      end else if (!sat) begin
        cnt_d = cnt_q + 1'b1;
      end
      if (fall) begin
        high_d = cnt_q + 1'b1; // kept for uncorrected duty
      end
    end
  end

  // registers only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      period_q <= '0;
      high_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      period_q <= period_d;
      high_q <= high_d;
    end
  end

  // ****************************************************************
  // lock detection
  // ****************************************************************
  logic locked;

  // held clear during loop reset so lock must be earned again
  dcg_lock_det #(
    .PW(PW),
    .LOCK_PERIODS(LOCK_PERIODS)
  ) u_lock (
    .mclk(mclk),
    .rstn(rstn),
    .clear(rst_sync_q),
    .sample(rise),
    .period(period_d),
    .locked(locked)
  );

  // ****************************************************************
  // predicted phase position
  // ****************************************************************
  logic [PW-1:0] pos_q, pos_d; // zero at the true source rising edge
  logic [PW-1:0] pos_inc;

  // the synchroniser and output register delay the seen edge, so the
  // position is re-anchored ahead by that latency; between edges it
  // free-runs and wraps, which puts phase zero on the real source edge
  always_comb begin
    pos_inc = pos_q + 1'b1;
    if (rst_sync_q) begin
      pos_d = '0;
    end else if (rise) begin
      pos_d = PW'(`DCG_COMP_LAT);
    end else if (pos_inc >= period_q) begin
      pos_d = '0;
    end else begin
      pos_d = pos_inc;
    end
  end

  // registers only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_q <= '0;
    end else begin
      pos_q <= pos_d;
    end
  end

  // ****************************************************************
  // 1x outputs: zero, 90, 180 and 270 degrees
  // ****************************************************************
  logic [PW-1:0] half, quarter, width;
  logic [PW-1:0] shift_tab [4];
  logic [3:0] tap_en;
  logic [3:0] tap_bits;
  logic run;

  // outputs stay low during loop reset; with correction off the measured
  // high time is reused, so jitter on the source duty passes through
  always_comb begin
    run = ~rst_sync_q;
    half = period_q >> 1;
    quarter = period_q >> 2;
    width = cfg.dcc_enable ? half : high_q;
    shift_tab[0] = '0;
    shift_tab[1] = quarter;
    shift_tab[2] = half;
    shift_tab[3] = half + quarter;
    tap_en[0] = run;
    tap_en[1] = run & ~cfg.high_freq_mode;
    tap_en[2] = run;
    tap_en[3] = run & ~cfg.high_freq_mode;
  end

  // one tap per phase
  for (genvar g = 0; g < 4; g++) begin : g_tap
    dcg_phase_tap #(
      .PW(PW)
    ) u_tap (
      .mclk(mclk),
      .rstn(rstn),
      .pos(pos_q),
      .period(period_q),
      .shift(shift_tab[g]),
      .width(width),
      .enable(tap_en[g]),
      .tap_out(tap_bits[g])
    );
  end

  // ****************************************************************
  // doubled output
  // ****************************************************************
  logic dbl_q, dbl_d;
  logic [PW-1:0] pos2;

  // before lock a quarter-period pulse per source period lets the loop
  // pick the right edge; after lock two half-period cycles per period
  always_comb begin
    pos2 = (pos_q >= half) ? (pos_q - half) : pos_q;
    if (!run || cfg.high_freq_mode) begin
      dbl_d = 1'b0;
    end else if (locked) begin
      dbl_d = pos2 < (half >> 1);
    end else begin
      dbl_d = pos_q < quarter;
    end
  end

  // registers only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dbl_q <= `DCG_OUT_RST;
    end else begin
      dbl_q <= dbl_d;
    end
  end

  // ****************************************************************
  // divided output
  // ****************************************************************
  logic [`DCG_HU_W-1:0] hu;
  logic [DW-1:0] div_pos_q, div_pos_d, div_inc, div_tot, div_thr;
  logic div_q, div_d;

  // factor in half source periods, so 1.5 and 2.5 need no fractions
  always_comb begin
    unique case (cfg.divide_factor_cfg)
      DCG_DIV_1P5: hu = `DCG_HU_1P5;
      DCG_DIV_2: hu = `DCG_HU_2;
      DCG_DIV_2P5: hu = `DCG_HU_2P5;
      DCG_DIV_3: hu = `DCG_HU_3;
      DCG_DIV_4: hu = `DCG_HU_4;
      DCG_DIV_5: hu = `DCG_HU_5;
      DCG_DIV_8: hu = `DCG_HU_8;
      DCG_DIV_16: hu = `DCG_HU_16;
    endcase
  end

  // high-frequency non-integer factors give a whole number of half periods
  // high: one of three for 1.5, two of five for 2.5
  always_comb begin
    div_tot = DW'(hu) * DW'(half);
    div_inc = div_pos_q + 1'b1;
    if (cfg.high_freq_mode && cfg.divide_factor_cfg == DCG_DIV_1P5) begin
      div_thr = DW'(half);
    end else if (cfg.high_freq_mode && cfg.divide_factor_cfg == DCG_DIV_2P5) begin
      div_thr = DW'(half) << 1;
    end else begin
      div_thr = div_tot >> 1;
    end
    if (!run) begin
      div_pos_d = '0;
    end else if (div_inc >= div_tot) begin
      div_pos_d = '0;
    end else begin
      div_pos_d = div_inc;
    end
    div_d = run & (div_pos_q < div_thr);
  end

  // registers only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_pos_q <= '0;
      div_q <= `DCG_OUT_RST;
    end else begin
      div_pos_q <= div_pos_d;
      div_q <= div_d;
    end
  end

  // ****************************************************************
  // status and configuration hold-off
  // ****************************************************************
  logic lock_q, lock_d;
  logic rel_q, rel_d;

  // lock is reported one cycle after the detector so it lines up with
  // the registered clocks; downstream logic must ignore clocks until then
  always_comb begin
    lock_d = locked & run;
    rel_d = config_done_in & (~cfg.hold_config_until_lock | lock_q);
  end

  // registers only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= `DCG_LOCK_RST;
      rel_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
      rel_q <= rel_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign clk_out.phase0_out = tap_bits[0];
  assign clk_out.phase90_out = tap_bits[1];
  assign clk_out.phase180_out = tap_bits[2];
  assign clk_out.phase270_out = tap_bits[3];
  assign clk_out.double_freq_out = dbl_q;
  assign clk_out.divided_clk_out = div_q;
  assign locked_out = lock_q;
  assign config_release_out = rel_q;
endmodule
`default_nettype wire

/* verification/dcg_top_assertions.sv */
// port checker of the clock output generator
// assumes bind into dcg_top and a source period of at least 8 mclk
`timescale 1ns/1ps
`default_nettype none
module dcg_top_checker #(
  parameter int PW = 12,
  parameter int LOCK_PERIODS = 3000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // pins and configuration
  input wire logic source_clk_in,
  input wire logic loop_rst_in,
  input wire dcg_pkg::dcg_cfg_type cfg,
  input wire logic config_done_in,
  // generated clocks and status
  input wire dcg_pkg::dcg_clk_out_type clk_out,
  input wire logic locked_out,
  input wire logic config_release_out
);
  import dcg_pkg::*;
  // ****************************************
  // cycles since the loop reset pin fell
  // ****************************************
  logic [15:0] run_q; // saturates so it never wraps into a false low count
  logic [15:0] run_d;
  // next value: cleared by the pin, else counts up
  always_comb begin
    run_d = loop_rst_in ? 16'h0000 : run_q + {15'h0000, run_q != 16'hffff};
  end
  // register only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) run_q <= 16'h0000;
    else run_q <= run_d;
  end
  // ****************************************
  // source rises seen since the loop reset pin fell
  // ****************************************
  logic src_prev_q; // pin level at the previous edge
  logic [1:0] edges_q; // saturates at three
  logic [1:0] edges_d;
  // next value: the first period measured after release is partial and may
  // give short pulses, so the doubled clock is judged once three rises passed
  always_comb begin
    edges_d = loop_rst_in ? 2'h0
      : edges_q + {1'b0, source_clk_in && !src_prev_q && edges_q != 2'h3};
  end
  // registers only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_prev_q <= 1'b0;
      edges_q <= 2'h0;
    end else begin
      src_prev_q <= source_clk_in;
      edges_q <= edges_d;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_release_follow: assert property (@(posedge mclk) disable iff (!rstn)
    $past(rstn) |-> config_release_out ==
      $past(config_done_in && (!cfg.hold_config_until_lock || locked_out)))
    else $error("config release does not follow done and lock");
  a_fast_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    cfg.high_freq_mode |-> !clk_out.double_freq_out && !clk_out.phase90_out
      && !clk_out.phase270_out)
    else $error("output driven that the high frequency loop lacks");
  a_loop_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    loop_rst_in [*5] |-> clk_out == 6'h00)
    else $error("clocks still running under loop reset");
  a_lock_drop: assert property (@(posedge mclk) disable iff (!rstn)
    loop_rst_in [*6] |-> !locked_out)
    else $error("lock held under loop reset");
  a_lock_early: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(locked_out) |-> run_q >= 16'(LOCK_PERIODS * 8))
    else $error("lock reported too soon after loop reset");
  a_tap_straddle: assert property (@(posedge mclk) disable iff (!rstn)
    locked_out && cfg.dcc_enable && !cfg.high_freq_mode && $rose(clk_out.phase0_out)
      |-> !clk_out.phase90_out && !clk_out.phase180_out && clk_out.phase270_out)
    else $error("shifted taps out of place at phase zero rise");
  a_lag_ninety: assert property (@(posedge mclk) disable iff (!rstn)
    locked_out && !cfg.high_freq_mode && $rose(clk_out.phase0_out)
      |=> !clk_out.phase90_out [*2])
    else $error("quarter tap rises too early");
  a_double_width: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg.high_freq_mode && !loop_rst_in && edges_q == 2'h3
      && $rose(clk_out.double_freq_out)
      |=> clk_out.double_freq_out)
    else $error("doubled clock pulse too short");
endmodule
bind dcg_top dcg_top_checker #(.PW(PW), .LOCK_PERIODS(LOCK_PERIODS)) i_dcg_top_checker (
  .mclk(mclk), .rstn(rstn), .source_clk_in(source_clk_in), .loop_rst_in(loop_rst_in),
  .cfg(cfg), .config_done_in(config_done_in), .clk_out(clk_out),
  .locked_out(locked_out), .config_release_out(config_release_out));
`default_nettype wire

/* verification/dcg_src_model.sv */
// source oscillator model feeding the loop, times in mclk cycles
// assumes the bench holds period and high time steady while running
`timescale 1ns/1ps
`default_nettype none
module dcg_src_model (
  // clock
  input wire logic mclk,
  // waveform control
  input wire logic run,
  input wire logic [11:0] period,
  input wire logic [11:0] high_time,
  // source pin
  output logic source_clk_in
);
  logic [11:0] cnt_q = 12'h000; // position in the source period
  // fixed frequency; the pin stands low when stopped
  always @(posedge mclk) begin
    cnt_q <= #1 (!run || cnt_q >= period - 12'h001) ? 12'h000 : cnt_q + 12'h001;
    source_clk_in <= #1 run && (cnt_q < high_time);
  end
  initial source_clk_in = 1'b0;
endmodule
`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the clock output generator, source period 16 mclk
// assumes the source model and the port checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
`include "dcg_cfg.svh"
module tb;
  import dcg_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int LOCKN = 8; // short lock count keeps the run brief
  localparam int P0 = 5; // bit positions in the clock bundle
  localparam int DBL = 1;
  localparam int DIV = 0;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic loop_rst_in = 1'b1;
  logic config_done_in = 1'b1;
  logic [11:0] src_hi = 12'h008;
  dcg_cfg_type cfg = {1'b0, 1'b1, 1'b1, DCG_DIV_2};
  logic source_clk_in;
  dcg_clk_out_type clk_out;
  logic locked_out;
  logic config_release_out;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int hi[6]; // high cycles per output in a window
  int ri[6]; // rising edges per output in a window
  int hu[8] = '{`DCG_HU_1P5, `DCG_HU_2, `DCG_HU_2P5, `DCG_HU_3, `DCG_HU_4, `DCG_HU_5,
    `DCG_HU_8, `DCG_HU_16};
  int d;
  always #12.5 mclk = ~mclk;
  dcg_src_model i_dcg_src_model (.mclk(mclk), .run(1'b1), .period(12'h010),
    .high_time(src_hi), .source_clk_in(source_clk_in));
  dcg_top #(.LOCK_PERIODS(LOCKN)) i_dcg_top (.mclk(mclk), .rstn(rstn),
    .source_clk_in(source_clk_in), .loop_rst_in(loop_rst_in), .cfg(cfg),
    .config_done_in(config_done_in), .clk_out(clk_out), .locked_out(locked_out),
    .config_release_out(config_release_out));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask
  // counts high cycles and rises; a whole number of periods makes phase irrelevant
  task automatic measure(input int n);
    logic [5:0] prev;
    logic [5:0] now;
    tick(1);
    prev = clk_out;
    hi = '{0, 0, 0, 0, 0, 0};
    ri = '{0, 0, 0, 0, 0, 0};
    repeat (n) begin
      tick(1);
      now = clk_out;
      for (int i = 0; i < 6; i++) begin
        hi[i] += int'(now[i] === 1'b1);
        ri[i] += int'(now[i] === 1'b1 && prev[i] === 1'b0);
      end
      prev = now;
    end
  endtask
  // cycles from a phase zero rise to the next rise of output bit b
  task automatic lag(input int b, output int dl);
    logic w;
    logic c;
    int n;
    n = 0;
    dl = 0;
    c = clk_out[P0];
    do begin
      tick(1);
      n++;
      w = c;
      c = clk_out[P0];
    end while (!(c === 1'b1 && w === 1'b0) && n < 64);
    c = clk_out[b];
    do begin
      tick(1);
      dl++;
      w = c;
      c = clk_out[b];
    end while (!(c === 1'b1 && w === 1'b0) && dl < 64);
  endtask
  // loop reset only around a change of setup; before lock the quiet outputs and lock under reset, then lock, release and the doubled clock are checked
  task automatic relock(input logic fast, input logic dcc, input logic hold,
    input dcg_div_type dv, input logic [11:0] h);
    loop_rst_in = 1'b1;
    tick(8);
    check({10'h000, clk_out}, 16'h0000);
    check({15'h0000, locked_out}, 16'h0000);
    cfg = {fast, dcc, hold, dv};
    src_hi = h;
    tick(4);
    loop_rst_in = 1'b0;
    tick(48);
    measure(32);
    check({15'h0000, locked_out}, 16'h0000);
    check({15'h0000, config_release_out}, {15'h0000, !hold});
    if (!fast) check(16'(hi[DBL] * 16 + ri[DBL]), 16'h0082);
    d = 0;
    while (locked_out !== 1'b1 && d < 1000) begin
      tick(1);
      d++;
    end
    tick(1);
    check({14'h0000, locked_out, config_release_out}, 16'h0003);
  endtask
  // ****************************************
  // watchdog and sequence
  // ****************************************
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    tick(12);
    rstn = 1'b1;
    relock(1'b0, 1'b1, 1'b1, DCG_DIV_2, 12'h008);
    measure(64);
    for (int i = 2; i < 6; i++) check(16'(hi[i]), 16'h0020);
    check(16'(ri[P0]), 16'h0004);
    check(16'(hi[DBL] * 16 + ri[DBL]), 16'h0208);
    check(16'(hi[DIV] * 16 + ri[DIV]), 16'h0202);
    for (int k = 1; k < 4; k++) begin
      lag(P0 - k, d);
      check(16'(d), 16'(4 * k));
    end
    $display("test phases done");
    for (int f = 0; f < 8; f++) begin
      relock(1'b0, 1'b1, 1'b0, dcg_div_type'(f), 12'h008);
      measure(16 * hu[f]);
      check(16'(hi[DIV] * 16 + ri[DIV]), 16'(hu[f] * 128 + 2));
    end
    $display("test divide factors done");
    relock(1'b1, 1'b1, 1'b0, DCG_DIV_1P5, 12'h008);
    measure(48);
    check(16'(hi[DIV]), 16'h0010);
    check(16'(hi[4] + hi[2] + hi[DBL]), 16'h0000);
    check(16'(hi[3]), 16'h0018);
    relock(1'b1, 1'b1, 1'b0, DCG_DIV_2P5, 12'h008);
    measure(80);
    check(16'(hi[DIV]), 16'h0020);
    $display("test high frequency done");
    relock(1'b0, 1'b0, 1'b0, DCG_DIV_2, 12'h005);
    measure(64);
    check(16'(hi[P0] * 256 + hi[3]), 16'h1414);
    $display("test duty follow done");
    config_done_in = 1'b0;
    tick(2);
    check({15'h0000, config_release_out}, 16'h0000);
    $display("test release hold done");
    close_out();
  end
endmodule
`default_nettype wire
